/* File: core/access_port_fsm.sv */
// Access-side port control state machine of one basic-access user port.
// Assumes every input event is a single-cycle pulse on the system clock.
//
// Summary of operation
// - Exchange orders activation while operational
// - Access side controls activation when non-operational
// - Block request alone changes no state
// - Immediate block acts at once, no confirmation
// - Separate unblock states; operational after confirmation
// - Block in local unblock means refusal
// - Permanent line activation from blocked state
// - Loop tests entered from blocked or remote unblock
// - Loop tests exit only to blocked
// - Partial activation entry and exit limits
// - Partial activation exit to blocked sends access block command
// - Terminal deactivation only in partial activation
// - Channel suspend and resume keep state
// - Tracks layer-1 condition only, no calls
// - Far signal loss meaning depends on state
// - Management block sends command, deactivates port unless an active port has a provisioned permanent line
// - Exchange unblock enters remote unblock state
// - Block in remote unblock returns to blocked
`default_nettype none
`include "port_fsm_defs.svh"

module access_port_fsm (
    input  wire logic                       clock,
    input  wire logic                       rst_n,
    input  wire logic                       perm_line_provisioned,
    input  wire logic                       block_cmd_from_exchange,
    input  wire logic                       unblock_req_from_exchange,
    input  wire logic                       activate_from_exchange,
    input  wire logic                       deactivate_from_exchange,
    input  wire logic                       mgmt_block_ind,
    input  wire logic                       mgmt_block_req,
    input  wire logic                       mgmt_unblock_req,
    input  wire logic                       mgmt_perm_activate,
    input  wire logic                       mgmt_perm_deactivate,
    input  wire logic                       mgmt_loop_enter,
    input  wire logic                       mgmt_loop_exit,
    input  wire logic                       partial_activation_request,
    input  wire logic                       partial_exit_request,
    input  wire logic                       terminal_side_deactivation_request,
    input  wire logic                       far_signal_loss_error_ind,
    input  wire logic                       dchan_suspend_cmd,
    input  wire logic                       dchan_resume_cmd,
    input  wire logic                       ds_user_activate,
    input  wire logic                       ds_activated,
    output port_fsm_pkg::port_state_t       state,
    output logic                            operational,
    output logic                            access_has_control,
    output logic                            dchan_open,
    output logic                            block_cmd_from_access_side,
    output logic                            unblock_req_from_access_side,
    output logic                            block_request_to_exchange,
    output logic                            activation_ind_to_exchange,
    output logic                            activated_ind_to_exchange,
    output logic                            ds_activate_element,
    output logic                            port_deactivate_element,
    output logic                            partial_activation_element,
    output logic                            t_side_deactivate_element,
    output logic                            block_indication_primitive,
    output logic                            remote_unblock_ind,
    output logic                            unblock_confirm_ind,
    output logic                            unblock_refused_ind,
    output logic                            terminal_loss_ind,
    output logic                            perm_service_lost_ind
);
    import port_fsm_pkg::*;

    function automatic logic is_oper(input port_state_t s);
        return s inside {access_operational_deactivated, access_activation_initiated,
                         access_fully_activated};
    endfunction

    function automatic logic is_active(input port_state_t s);
        return s inside {access_activation_initiated, access_fully_activated,
                         perm_activation_initiated, perm_activated};
    endfunction

    port_state_t state_q, state_d;
    logic        part_from_op_q;
    logic [14:0] out_q, out_d;

    dchan_ctl_if dch ();

    ////////////////////////////////////////////////////////////////////////
    // Next-state and element decode
    always_comb begin
        state_d = state_q;
        out_d   = '0;
        if (mgmt_block_ind) begin
            out_d[0] = 1'b1;
            if (perm_line_provisioned && is_active(state_q)) begin
                state_d = perm_activated;
            end else begin
                state_d = access_blocked_state;
                out_d[6] = is_active(state_q);
            end
        end else if (block_cmd_from_exchange) begin
            case (state_q)
                access_remote_unblock_state: begin
                    state_d   = access_blocked_state;
                    out_d[9]  = 1'b1;
                end
                access_local_unblock_state: begin
                    out_d[12] = 1'b1;
                end
                access_operational_deactivated, access_activation_initiated,
                access_fully_activated: begin
                    if (perm_line_provisioned && is_active(state_q)) begin
                        state_d  = perm_activated;
                    end else begin
                        state_d  = access_blocked_state;
                        out_d[6] = is_active(state_q);
                    end
                end
                default: begin
                end
            endcase
        end else begin
            case (state_q)
                access_blocked_state: begin
                    if (mgmt_unblock_req) begin
                        state_d  = access_local_unblock_state;
                        out_d[1] = 1'b1;
                    end else if (unblock_req_from_exchange) begin
                        state_d   = access_remote_unblock_state;
                        out_d[10] = 1'b1;
                    end else if (mgmt_perm_activate && perm_line_provisioned) begin
                        state_d  = perm_activation_initiated;
                        out_d[5] = 1'b1;
                    end else if (mgmt_loop_enter) begin
                        state_d = access_loop_test_states;
                    end else if (partial_activation_request) begin
                        state_d  = access_partial_activation_states;
                        out_d[7] = 1'b1;
                    end
                end
                access_local_unblock_state: begin
                    if (unblock_req_from_exchange) begin
                        state_d   = access_operational_deactivated;
                        out_d[11] = 1'b1;
                    end
                end
                access_remote_unblock_state: begin
                    if (mgmt_unblock_req) begin
                        state_d  = access_operational_deactivated;
                        out_d[1] = 1'b1;
                    end else if (mgmt_loop_enter) begin
                        state_d = access_loop_test_states;
                    end
                end
                access_operational_deactivated: begin
                    if (activate_from_exchange) begin
                        state_d  = access_activation_initiated;
                        out_d[5] = 1'b1;
                    end else if (ds_user_activate) begin
                        state_d  = access_activation_initiated;
                        out_d[3] = 1'b1;
                    end else if (partial_activation_request) begin
                        state_d  = access_partial_activation_states;
                        out_d[7] = 1'b1;
                    end
                    out_d[2] = mgmt_block_req;
                end
                access_activation_initiated, access_fully_activated: begin
                    if (deactivate_from_exchange) begin
                        state_d  = access_operational_deactivated;
                        out_d[6] = 1'b1;
                    end else if (ds_activated && state_q == access_activation_initiated) begin
                        state_d  = access_fully_activated;
                        out_d[4] = 1'b1;
                    end
                    out_d[2]  = mgmt_block_req;
                    out_d[13] = far_signal_loss_error_ind
                                && state_q == access_fully_activated;
                end
                perm_activation_initiated, perm_activated: begin
                    if (mgmt_perm_deactivate) begin
                        state_d  = access_blocked_state;
                        out_d[6] = 1'b1;
                    end else if (ds_activated) begin
                        state_d = perm_activated;
                    end
                    out_d[14] = far_signal_loss_error_ind;
                end
                access_loop_test_states: begin
                    if (mgmt_loop_exit) begin
                        state_d = access_blocked_state;
                    end
                end
                access_partial_activation_states: begin
                    out_d[8] = terminal_side_deactivation_request;
                    if (partial_exit_request) begin
                        if (part_from_op_q) begin
                            state_d = access_operational_deactivated;
                        end else begin
                            state_d  = access_blocked_state;
                            out_d[0] = 1'b1;
                        end
                    end
                end
                default: begin
                    state_d = access_blocked_state;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            state_q <= access_blocked_state;
        end else begin
            state_q <= state_d;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            out_q <= '0;
        end else begin
            out_q <= out_d;
        end
    end

    // Remembers where partial activation came from
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            part_from_op_q <= `PART_FROM_OP_RESET;
        end else if (state_q != access_partial_activation_states
                     && state_d == access_partial_activation_states) begin
            part_from_op_q <= (state_q == access_operational_deactivated);
        end
    end

    assign dch.suspend     = dchan_suspend_cmd;
    assign dch.resume      = dchan_resume_cmd;
    assign dch.fully_act   = (state_q == access_fully_activated);
    assign dch.operational = is_oper(state_q);

    dchan_gate u_gate (
        .clock (clock),
        .rst_n (rst_n),
        .ctl   (dch.gate)
    );

    assign access_has_control           = !is_oper(state_q);
    assign operational                  = is_oper(state_q);
    assign state                        = state_q;
    assign dchan_open                   = dch.dchan_open;
    assign block_cmd_from_access_side   = out_q[0];
    assign unblock_req_from_access_side = out_q[1];
    assign block_request_to_exchange    = out_q[2];
    assign activation_ind_to_exchange   = out_q[3];
    assign activated_ind_to_exchange    = out_q[4];
    assign ds_activate_element          = out_q[5];
    assign port_deactivate_element      = out_q[6];
    assign partial_activation_element   = out_q[7];
    assign t_side_deactivate_element    = out_q[8];
    assign block_indication_primitive   = out_q[9];
    assign remote_unblock_ind           = out_q[10];
    assign unblock_confirm_ind          = out_q[11];
    assign unblock_refused_ind          = out_q[12];
    assign terminal_loss_ind            = out_q[13];
    assign perm_service_lost_ind        = out_q[14];

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    property p_mgmt_block;
        mgmt_block_ind |=> block_cmd_from_access_side
            && (state_q == access_blocked_state || state_q == perm_activated);
    endproperty
    a_mgmt_block: assert property (p_mgmt_block)
        else $error("management block not applied");

    property p_remote_block;
        !mgmt_block_ind && block_cmd_from_exchange
            && state_q == access_remote_unblock_state
        |=> state_q == access_blocked_state && block_indication_primitive;
    endproperty
    a_remote_block: assert property (p_remote_block)
        else $error("remote unblock not undone");

    property p_local_refuse;
        !mgmt_block_ind && block_cmd_from_exchange
            && state_q == access_local_unblock_state
        |=> $stable(state_q) && unblock_refused_ind;
    endproperty
    a_local_refuse: assert property (p_local_refuse)
        else $error("refusal mishandled");

    property p_loop_entry;
        state_q == access_loop_test_states && !$stable(state_q)
        |-> $past(state_q) inside {access_blocked_state, access_remote_unblock_state};
    endproperty
    a_loop_entry: assert property (p_loop_entry)
        else $error("loop entered from wrong state");

    property p_loop_exit;
        $past(state_q) == access_loop_test_states && state_q != access_loop_test_states
        |-> state_q == access_blocked_state;
    endproperty
    a_loop_exit: assert property (p_loop_exit)
        else $error("loop exit not to blocked");

    property p_part_exit;
        $past(state_q) == access_partial_activation_states
            && state_q == access_blocked_state
        |-> block_cmd_from_access_side;
    endproperty
    a_part_exit: assert property (p_part_exit)
        else $error("partial exit without block command");

    property p_tside;
        t_side_deactivate_element |-> $past(state_q) == access_partial_activation_states;
    endproperty
    a_tside: assert property (p_tside)
        else $error("terminal deactivation outside partial activation");

    property p_suspend_keep;
        state_q == access_fully_activated && (dchan_suspend_cmd || dchan_resume_cmd)
            && !mgmt_block_ind && !block_cmd_from_exchange
            && !deactivate_from_exchange
        |=> state_q == access_fully_activated;
    endproperty
    a_suspend_keep: assert property (p_suspend_keep)
        else $error("channel command changed state");

    property p_oper_entry;
        state_q == access_operational_deactivated
            && $past(state_q) inside {access_local_unblock_state, access_remote_unblock_state}
        |-> unblock_confirm_ind || unblock_req_from_access_side;
    endproperty
    a_oper_entry: assert property (p_oper_entry)
        else $error("operational without confirmation");

    property p_perm_loss;
        state_q == perm_activated && far_signal_loss_error_ind && !mgmt_block_ind
            && !block_cmd_from_exchange
        |=> perm_service_lost_ind;
    endproperty
    a_perm_loss: assert property (p_perm_loss)
        else $error("permanent service loss not reported");

    c_unblock_remote: cover property (state_q == access_remote_unblock_state
        ##[1:20] state_q == access_operational_deactivated);
    c_full_act: cover property (state_q == access_fully_activated);
    c_perm: cover property (state_q == perm_activated);
    c_part_back: cover property (state_q == access_partial_activation_states
        ##[1:20] state_q == access_blocked_state);

endmodule

`default_nettype wire

/* File: core/dchan_ctl_if.sv */
// Carrier between the port state machine and its signalling channel gate.
// Assumes both ends share one clock.
`default_nettype none

interface dchan_ctl_if;
    logic suspend;
    logic resume;
    logic fully_act;
    logic operational;
    logic dchan_open;

    modport fsm  (output suspend, output resume, output fully_act,
                  output operational, input dchan_open);
    modport gate (input suspend, input resume, input fully_act,
                  input operational, output dchan_open);
endinterface

`default_nettype wire

/* File: core/dchan_gate.sv */
// Signalling channel gate of one user port.
// Assumes single-cycle suspend and resume pulses on the system clock.
`default_nettype none
`include "port_fsm_defs.svh"

module dchan_gate (
    input  wire logic     clock,
    input  wire logic     rst_n,
    dchan_ctl_if.gate     ctl
);
    import port_fsm_pkg::*;

    logic enable_q;

    ////////////////////////////////////////////////////////////////////////
    // suspend or resume
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            enable_q <= 1'b1;
        end else if (ctl.fully_act && ctl.suspend) begin
            enable_q <= 1'b0;
        end else if (ctl.fully_act && ctl.resume) begin
            enable_q <= 1'b1;
        end
    end

    // Channel only carries frames while operational and not suspended
    logic open_q;
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            open_q <= `DCHAN_OPEN_RESET;
        end else begin
            open_q <= enable_q && ctl.operational;
        end
    end
    assign ctl.dchan_open = open_q;

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    property p_suspend_closes;
        ctl.fully_act && ctl.suspend ##1 ctl.operational |=> !ctl.dchan_open;
    endproperty
    a_suspend_closes: assert property (p_suspend_closes)
        else $error("channel open after suspend");

endmodule

`default_nettype wire

/* File: core/port_fsm_defs.svh */
// Constants for the access-side port control state machine.
// Assumes inclusion by bare name from core/ sources only.
`ifndef PORT_FSM_DEFS_SVH
`define PORT_FSM_DEFS_SVH

// Signalling channel state after reset: closed
`define DCHAN_OPEN_RESET 1'b0
// Partial-activation return flag after reset: return to blocked
`define PART_FROM_OP_RESET 1'b0

`endif

/* File: core/port_fsm_pkg.sv */
// Types shared by the access-side port control logic.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none

package port_fsm_pkg;

    typedef enum logic [3:0] {
        access_blocked_state,
        access_local_unblock_state,
        access_remote_unblock_state,
        access_operational_deactivated,
        access_activation_initiated,
        access_fully_activated,
        perm_activation_initiated,
        perm_activated,
        access_loop_test_states,
        access_partial_activation_states
    } port_state_t;

endpackage

`default_nettype wire

/* File: sim/exchange_peer.sv */
// Behavioural exchange-side peer facing the access port state machine.
// Assumes single-cycle command pulses from the bench on the shared clock.
`default_nettype none

module exchange_peer (
    input  wire logic clock,
    input  wire logic rst_n,
    input  wire logic slow,
    input  wire logic cmd_block,
    input  wire logic cmd_unblock,
    input  wire logic cmd_act,
    input  wire logic cmd_deact,
    input  wire logic perm_line,
    input  wire logic block_cmd_from_access_side,
    input  wire logic unblock_req_from_access_side,
    output logic      block_cmd_from_exchange,
    output logic      unblock_req_from_exchange,
    output logic      activate_from_exchange,
    output logic      deactivate_from_exchange
);
    timeunit 1ns;
    timeprecision 1ns;
    logic       local_q;
    logic       op_q;
    logic [2:0] wait_q;
    logic       confirm;
    ////////////////////////////////////////////////////////////
    // local unblock until answered
    always_ff @(posedge clock) begin
        if (!rst_n || cmd_block || unblock_req_from_access_side) begin
            local_q <= 1'b0;
        end else if (cmd_unblock) begin
            local_q <= 1'b1;
        end
    end
    // confirm a remote unblock, promptly or slowly
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            wait_q <= 3'h0;
        end else if (unblock_req_from_access_side && !local_q) begin
            wait_q <= slow ? 3'h5 : 3'h1;
        end else if (wait_q != 3'h0) begin
            wait_q <= wait_q - 3'h1;
        end
    end
    always_ff @(posedge clock) begin
        if (!rst_n || cmd_block || block_cmd_from_access_side) begin
            op_q <= 1'b0;
        end else if (confirm || (local_q && unblock_req_from_access_side)) begin
            op_q <= 1'b1;
        end
    end
    assign confirm                   = (wait_q == 3'h1);
    assign block_cmd_from_exchange   = cmd_block;
    assign unblock_req_from_exchange = cmd_unblock || confirm;
    assign activate_from_exchange    = cmd_act && op_q;
    assign deactivate_from_exchange  = cmd_deact && op_q && !perm_line;
endmodule

`default_nettype wire

/* File: sim/isdn_port_block_fsm_test.sv */
// Self-checking bench for the access port state machine.
// Assumes the exchange peer model and the design package are compiled first.
`default_nettype none

module isdn_port_block_fsm_test;
    timeunit 1ns;
    timeprecision 1ns;
    import port_fsm_pkg::*;
    localparam int MBI = 0, MBR = 1, MUB = 2, MPA = 3, MPD = 4, MLE = 5, MLX = 6, PAR = 7, PXR = 8;
    localparam int TSR = 9, FSL = 10, SUS = 11, RES = 12, DSV = 14, XBL = 15, XUB = 16, XAC = 17;
    localparam int DUA = 13, XDE = 18;
    localparam logic [14:0] BCA = 15'h4000, UBA = 15'h2000, BRQ = 15'h1000, ADX = 15'h0400;
    localparam logic [14:0] DSA = 15'h0200, PDE = 15'h0100, PAE = 15'h0080, TSD = 15'h0040;
    localparam logic [14:0] BIP = 15'h0020, RUI = 15'h0010, UCI = 15'h0008, URI = 15'h0004;
    localparam logic [14:0] TLI = 15'h0002, PSL = 15'h0001, AIX = 15'h0800, NONE = 15'h0000;
    logic        clock, rst_n, slow, prov, ublk, blk, act, deact, bca, uba;
    logic [18:0] ev;
    wire  [14:0] pulses;
    logic [14:0] exp_q[$];
    port_state_t state;
    logic        operational, has_ctl, dchan_open;
    int          fails, comparisons, seed;
    int          ign[10] = '{MPA, MPD, MLX, PXR, TSR, FSL, SUS, RES, DSV, XBL};

    exchange_peer peer_u (.clock(clock), .rst_n(rst_n), .slow(slow), .cmd_block(ev[15]),
        .cmd_unblock(ev[16]), .cmd_act(ev[17]), .block_cmd_from_access_side(bca),
        .cmd_deact(ev[18]), .perm_line(prov),
        .unblock_req_from_access_side(uba), .block_cmd_from_exchange(blk),
        .unblock_req_from_exchange(ublk), .activate_from_exchange(act),
        .deactivate_from_exchange(deact));
    access_port_fsm dut_u (.clock(clock), .rst_n(rst_n), .perm_line_provisioned(prov),
        .block_cmd_from_exchange(blk), .unblock_req_from_exchange(ublk),
        .activate_from_exchange(act), .deactivate_from_exchange(deact),
        .mgmt_block_ind(ev[0]), .mgmt_block_req(ev[1]), .mgmt_unblock_req(ev[2]),
        .mgmt_perm_activate(ev[3]), .mgmt_perm_deactivate(ev[4]), .mgmt_loop_enter(ev[5]),
        .mgmt_loop_exit(ev[6]), .partial_activation_request(ev[7]),
        .partial_exit_request(ev[8]), .terminal_side_deactivation_request(ev[9]),
        .far_signal_loss_error_ind(ev[10]), .dchan_suspend_cmd(ev[11]),
        .dchan_resume_cmd(ev[12]), .ds_user_activate(ev[13]), .ds_activated(ev[14]),
        .state(state), .operational(operational), .access_has_control(has_ctl),
        .dchan_open(dchan_open), .block_cmd_from_access_side(bca),
        .unblock_req_from_access_side(uba), .block_request_to_exchange(pulses[12]),
        .activation_ind_to_exchange(pulses[11]), .activated_ind_to_exchange(pulses[10]),
        .ds_activate_element(pulses[9]), .port_deactivate_element(pulses[8]),
        .partial_activation_element(pulses[7]), .t_side_deactivate_element(pulses[6]),
        .block_indication_primitive(pulses[5]), .remote_unblock_ind(pulses[4]),
        .unblock_confirm_ind(pulses[3]), .unblock_refused_ind(pulses[2]),
        .terminal_loss_ind(pulses[1]), .perm_service_lost_ind(pulses[0]));
    assign pulses[14:13] = {bca, uba};
    ////////////////////////////////////////////////////////////
    task automatic wrap_up();
        if (fails == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic check(input logic [14:0] got, input logic [14:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("BAD %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic fire(input int idx, input port_state_t st, input logic [14:0] p);
        if (p !== NONE) exp_q.push_back(p);
        @(posedge clock);
        #1 ev[idx] = 1'b1;
        @(posedge clock);
        #1 ev[idx] = 1'b0;
        check(15'(state), 15'(st), "state");
    endtask
    task automatic wait_state(input port_state_t st);
        int n;
        for (n = 0; n < 20 && state !== st; n++) @(posedge clock) #1;
        if (state !== st) begin
            fails++;
            $display("BAD %0t timeout waiting for state", $time);
            wrap_up();
        end
    endtask
    task automatic up();
        fire(MUB, access_local_unblock_state, UBA);
        exp_q.push_back(UCI);
        wait_state(access_operational_deactivated);
    endtask
    task automatic dchan_after(input logic e);
        repeat (2) @(posedge clock);
        #1 check(15'(dchan_open), 15'(e), "dchan");
    endtask
    ////////////////////////////////////////////////////////////
    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end
    always @(negedge clock) begin
        if (rst_n && pulses !== NONE) begin
            if (exp_q.size() == 0) check(pulses, NONE, "pulse");
            else check(pulses, exp_q.pop_front(), "pulse");
        end
    end
    initial begin
        {rst_n, slow, prov, ev, fails, comparisons, seed} = '0;
        seed = 79;
        slow = 1'b1;
        repeat (3) @(posedge clock);
        #1 rst_n = 1'b1;
        check(15'({state, operational, has_ctl, dchan_open}), 15'h0002, "reset");
        for (int i = 0; i < 8; i++) fire(ign[$unsigned($random(seed)) % 10], access_blocked_state, NONE);
        fire(XUB, access_remote_unblock_state, RUI);
        fire(XBL, access_blocked_state, BIP);
        fire(MLE, access_loop_test_states, NONE);
        fire(MLX, access_blocked_state, NONE);
        fire(XUB, access_remote_unblock_state, RUI);
        fire(MLE, access_loop_test_states, NONE);
        fire(XBL, access_loop_test_states, NONE);
        fire(MLX, access_blocked_state, NONE);
        fire(MUB, access_local_unblock_state, UBA);
        fire(XBL, access_local_unblock_state, URI);
        exp_q.push_back(UCI);
        wait_state(access_operational_deactivated);
        check(15'({operational, has_ctl}), 15'h0002, "control");
        fire(MBR, access_operational_deactivated, BRQ);
        fire(XAC, access_activation_initiated, DSA);
        fire(DSV, access_fully_activated, ADX);
        fire(SUS, access_fully_activated, NONE);
        dchan_after(1'b0);
        fire(RES, access_fully_activated, NONE);
        dchan_after(1'b1);
        fire(FSL, access_fully_activated, TLI);
        fire(XDE, access_operational_deactivated, PDE);
        fire(XAC, access_activation_initiated, DSA);
        fire(MBI, access_blocked_state, BCA | PDE);
        prov = 1'b1;
        slow = 1'b0;
        up();
        fire(XAC, access_activation_initiated, DSA);
        fire(DSV, access_fully_activated, ADX);
        fire(XDE, access_fully_activated, NONE);
        fire(MBI, perm_activated, BCA);
        fire(FSL, perm_activated, PSL);
        fire(MPD, access_blocked_state, PDE);
        fire(MPA, perm_activation_initiated, DSA);
        fire(DSV, perm_activated, NONE);
        fire(MPD, access_blocked_state, PDE);
        prov = 1'b0;
        fire(PAR, access_partial_activation_states, PAE);
        fire(TSR, access_partial_activation_states, TSD);
        fire(PXR, access_blocked_state, BCA);
        up();
        fire(PAR, access_partial_activation_states, PAE);
        fire(PXR, access_operational_deactivated, NONE);
        fire(DUA, access_activation_initiated, AIX);
        fire(MBI, access_blocked_state, BCA | PDE);
        repeat (3) @(posedge clock);
        check(15'(exp_q.size()), NONE, "pending");
        wrap_up();
    end
endmodule

`default_nettype wire
